// ===== idt_pkg.sv
// constants and types for the drive data timing register bank
// recovery, then the next cycle may start.
package idt_pkg;
    localparam int NUM_REGS = 8;
    localparam int ADDR_W   = 12;
    // register indexes; byte address is four times the index
    localparam logic [7:0] IDX_C1D1_RD = 8'h44;
    localparam logic [7:0] IDX_C1D1_WR = 8'h45;
    localparam logic [7:0] IDX_C1D2_RD = 8'h48;
    localparam logic [7:0] IDX_C1D2_WR = 8'h49;
    localparam logic [7:0] IDX_C2D1_RD = 8'h4C;
    localparam logic [7:0] IDX_C2D1_WR = 8'h4D;
    localparam logic [7:0] IDX_C2D2_RD = 8'h50;
    localparam logic [7:0] IDX_C2D2_WR = 8'h51;
    // field layout
    localparam int ACT_LSB = 0;
    localparam int REC_LSB = 4;
    localparam int FLD_W   = 4;
    // reset values (mode 0)
    localparam logic [3:0] ACT_RESET = 4'h5;
    localparam logic [3:0] REC_RESET = 4'h8;
    // code to clock count bases
    localparam logic [4:0] ACT_BASE = 5'h11;
    localparam logic [4:0] REC_BASE = 5'h10;

    typedef enum logic [1:0] {
        IDT_IDLE,
        IDT_ACTIVE,
        IDT_RECOVER
    } idt_state_type;
endpackage

// ===== idt_timing_regs.sv
// drive data timing registers on apb with a data cycle strobe engine
`timescale 1ns/1ps
module idt_timing_regs (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [idt_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // data cycle request
    input  wire logic                        cyc_req,
    input  wire logic                        cyc_chan,
    input  wire logic                        cyc_drive,
    input  wire logic                        cyc_write,
    output logic                             cyc_busy,
    output logic                             cyc_done,
    // drive strobes
    output logic                             strobe_chan,
    output logic                             rd_strobe_n,
    output logic                             wr_strobe_n
);
    import idt_pkg::*;

    logic [7:0]    timing [NUM_REGS];
    logic [3:0]    sel;
    logic          access;
    logic [4:0]    cnt;
    logic [7:0]    cur;
    logic [2:0]    req_slot;
    idt_state_type state;

    // slot number, or 8 when the address maps to nothing
    function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        if (a[1:0] != 2'b00 || a[ADDR_W-1:10] != '0) begin
            return 4'h8;
        end
        unique case (idx)
            IDX_C1D1_RD: return 4'h0;
            IDX_C1D1_WR: return 4'h1;
            IDX_C1D2_RD: return 4'h2;
            IDX_C1D2_WR: return 4'h3;
            IDX_C2D1_RD: return 4'h4;
            IDX_C2D1_WR: return 4'h5;
            IDX_C2D2_RD: return 4'h6;
            IDX_C2D2_WR: return 4'h7;
            default:     return 4'h8;
        endcase
    endfunction

    // clocks for a 4-bit code: base minus code
    function automatic logic [4:0] clocks(input logic [4:0] base,
                                          input logic [3:0] code);
        return base - {1'b0, code};
    endfunction

    assign sel      = decode(paddr);
    assign access   = psel & penable;
    assign req_slot = {cyc_chan, cyc_drive, cyc_write};

    // one wait state so every apb output comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (access && !pready) begin
            pready  <= 1'b1;
            pslverr <= sel[3];
            prdata  <= (sel[3] || pwrite) ? 32'h0000_0000
                                          : {24'h00_0000, timing[sel[2:0]]};
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // register writes land on the completing edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                timing[i] <= {REC_RESET, ACT_RESET};
            end
        end else if (access && pready && pwrite && !sel[3]) begin
            timing[sel[2:0]] <= pwdata[7:0];
        end
    end

    // cycle engine; a new request waits for recovery to end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= IDT_IDLE;
            cnt         <= 5'h00;
            cur         <= 8'h00;
            cyc_busy    <= 1'b0;
            cyc_done    <= 1'b0;
            strobe_chan <= 1'b0;
            rd_strobe_n <= 1'b1;
            wr_strobe_n <= 1'b1;
        end else begin
            cyc_done <= 1'b0;
            unique case (state)
                IDT_IDLE: begin
                    if (cyc_req) begin
                        cur         <= timing[req_slot];
                        cnt         <= clocks(ACT_BASE,
                            timing[req_slot][ACT_LSB +: FLD_W]) - 5'h01;
                        state       <= IDT_ACTIVE;
                        cyc_busy    <= 1'b1;
                        strobe_chan <= cyc_chan;
                        rd_strobe_n <= cyc_write;
                        wr_strobe_n <= ~cyc_write;
                    end
                end
                IDT_ACTIVE: begin
                    if (cnt == 5'h00) begin
                        rd_strobe_n <= 1'b1;
                        wr_strobe_n <= 1'b1;
                        cnt   <= clocks(REC_BASE,
                            cur[REC_LSB +: FLD_W]) - 5'h01;
                        state <= IDT_RECOVER;
                    end else begin
                        cnt <= cnt - 5'h01;
                    end
                end
                IDT_RECOVER: begin
                    if (cnt == 5'h00) begin
                        state    <= IDT_IDLE;
                        cyc_busy <= 1'b0;
                        cyc_done <= 1'b1;
                    end else begin
                        cnt <= cnt - 5'h01;
                    end
                end
            endcase
        end
    end
endmodule

// ===== idt_timing_regs_checker.sv
// port assertions for the drive timing register bank
`timescale 1ns/1ps
module idt_checker (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb answer
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // cycle engine
    input wire logic        cyc_busy,
    input wire logic        cyc_done,
    input wire logic        rd_strobe_n,
    input wire logic        wr_strobe_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_one_strobe: assert property (rd_strobe_n || wr_strobe_n)
        else $error("both strobes low");
    chk_rd_width: assert property ($fell(rd_strobe_n) |=>
        !rd_strobe_n ##[1:16] rd_strobe_n) else $error("read strobe width");
    chk_wr_width: assert property ($fell(wr_strobe_n) |=>
        !wr_strobe_n ##[1:16] wr_strobe_n) else $error("write strobe width");
    chk_rec_min: assert property ($rose(rd_strobe_n)
        || $rose(wr_strobe_n) |-> cyc_busy) else $error("no recovery");
    chk_done_end: assert property (cyc_done |->
        !cyc_busy && $past(cyc_busy)) else $error("done without busy");
    chk_busy_len: assert property ($rose(cyc_busy) |->
        ##[3:33] cyc_done) else $error("cycle length");
    chk_accept: assert property ($rose(cyc_busy) |->
        !(rd_strobe_n && wr_strobe_n)) else $error("strobe not started");
    chk_err_data: assert property (pslverr |->
        pready && prdata == 32'h0000_0000) else $error("error response");
endmodule
bind idt_timing_regs idt_checker chk_i (.pclk, .presetn, .pready, .pslverr,
    .cyc_busy, .cyc_done, .rd_strobe_n, .wr_strobe_n, .prdata);

// ===== idt_drive_model.sv
// drive model that times how long a strobe stays low
`timescale 1ns/1ps
module idt_drive_model (
    input  wire logic       pclk,
    input  wire logic       rd_strobe_n,
    input  wire logic       wr_strobe_n,
    output logic      [4:0] width
);
    logic [4:0] cnt = 5'h00;
    always_ff @(posedge pclk) begin
        if (!(rd_strobe_n && wr_strobe_n)) begin
            cnt <= cnt + 5'h01;
        end else if (cnt != 5'h00) begin
            width <= cnt;
            cnt <= 5'h00;
        end
    end
endmodule

// ===== idt_timing_regs_test.sv
// self-checking bench for the drive timing register bank
`timescale 1ns/1ps
module idt_timing_regs_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic cyc_req = 0, cyc_chan = 0, cyc_drive = 0, cyc_write = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, cyc_busy, cyc_done, strobe_chan;
    logic rd_strobe_n, wr_strobe_n;
    logic [4:0] width;
    int err_count = 0, compares = 0;
    idt_timing_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cyc_req, .cyc_chan, .cyc_drive,
        .cyc_write, .cyc_busy, .cyc_done, .strobe_chan, .rd_strobe_n,
        .wr_strobe_n);
    idt_drive_model drv (.pclk, .rd_strobe_n, .wr_strobe_n, .width);
    initial forever #2 pclk = ~pclk;
    function logic [11:0] ad(input int i);
        return 12'((8'h44 + i / 2 * 4 + i % 2) * 4);
    endfunction
    task chk(input logic [32:0] s, x);
        compares++;
        if (s !== x) begin
            err_count++;
            $display("unexpected at %0t: %h vs %h", $time, s, x);
        end
    endtask
    task finish_test;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1;
        // hold the request until pready is seen high at a rising edge
        do begin @(posedge pclk); n++; end while (!pready && n < 20);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        if (!pready) begin err_count++; finish_test; end
    endtask
    task cyc(input logic [2:0] s, input int a, r);
        int n;
        n = 0;
        @(posedge pclk) {cyc_chan, cyc_drive, cyc_write, cyc_req} <= {s, 1'b1};
        @(posedge pclk) cyc_req <= 0;
        do begin @(negedge pclk); n++; end while (!cyc_done && n < 40);
        if (!cyc_done) begin err_count++; finish_test; end
        chk(n - 1, a + r);
        chk(width, a);
        chk(strobe_chan, s[2]);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 8; i++) begin
            apb(0, ad(i), 8'h00);
            chk(q, 32'h0000_0085);
        end
        cyc(3'b000, 12, 8);
        for (int i = 0; i < 8; i++) apb(1, ad(i), 8'(i * 17 + 3));
        for (int i = 0; i < 8; i++) begin
            apb(0, ad(i), 8'h00);
            chk({e, q}, 33'(i * 17 + 3));
        end
        // high nibble is recovery, low nibble is active
        apb(1, ad(5), 8'hF0);
        cyc(3'b101, 17, 1);
        apb(1, ad(6), 8'h0F);
        cyc(3'b110, 2, 16);
        apb(0, 12'h150, 8'h00);
        chk({e, q}, 33'h1_0000_0000);
        finish_test;
    end
endmodule
